// ==== design/gpx_pkg.sv ====
// Shared constants for the 16-bit serial GPIO expander.
// Assumes one core clock and the serial clock as a second domain.
package gpx_pkg;
  localparam int GPX_PIN_W = 16;
  localparam int GPX_PORT_W = 8;
  // Upper bits of the bus address; the three select pins fill the rest
  localparam logic [3:0] GPX_ADDR_BASE = 4'h4;
  // Bit slot numbers counted on serial clock falls
  localparam logic [3:0] GPX_LAST_DATA = 4'h7;
  localparam logic [3:0] GPX_ACK_SLOT = 4'h8;
  // Command byte values (register pointer)
  localparam logic [7:0] GPX_IN0 = 8'h00;
  localparam logic [7:0] GPX_IN1 = 8'h01;
  localparam logic [7:0] GPX_OUT0 = 8'h02;
  localparam logic [7:0] GPX_OUT1 = 8'h03;
  localparam logic [7:0] GPX_POL0 = 8'h04;
  localparam logic [7:0] GPX_POL1 = 8'h05;
  localparam logic [7:0] GPX_CFG0 = 8'h06;
  localparam logic [7:0] GPX_CFG1 = 8'h07;
  localparam logic [7:0] GPX_DRV0A = 8'h40;
  localparam logic [7:0] GPX_DRV0B = 8'h41;
  localparam logic [7:0] GPX_DRV1A = 8'h42;
  localparam logic [7:0] GPX_DRV1B = 8'h43;
  localparam logic [7:0] GPX_LAT0 = 8'h44;
  localparam logic [7:0] GPX_LAT1 = 8'h45;
  localparam logic [7:0] GPX_PEN0 = 8'h46;
  localparam logic [7:0] GPX_PEN1 = 8'h47;
  localparam logic [7:0] GPX_PSEL0 = 8'h48;
  localparam logic [7:0] GPX_PSEL1 = 8'h49;
  localparam logic [7:0] GPX_MSK0 = 8'h4A;
  localparam logic [7:0] GPX_MSK1 = 8'h4B;
  localparam logic [7:0] GPX_IST0 = 8'h4C;
  localparam logic [7:0] GPX_IST1 = 8'h4D;
  localparam logic [7:0] GPX_OCFG = 8'h4F;
  // Power-up values
  localparam logic [15:0] GPX_RST_OUT = 16'hFFFF;
  localparam logic [15:0] GPX_RST_POL = 16'h0000;
  localparam logic [15:0] GPX_RST_CFG = 16'hFFFF;
  localparam logic [31:0] GPX_RST_DRV = 32'hFFFF_FFFF;
  localparam logic [15:0] GPX_RST_LAT = 16'h0000;
  localparam logic [15:0] GPX_RST_PEN = 16'hFFFF;
  localparam logic [15:0] GPX_RST_PSEL = 16'hFFFF;
  localparam logic [15:0] GPX_RST_MSK = 16'hFFFF;
  localparam logic [1:0] GPX_RST_OCFG = 2'h0;
  typedef enum logic [4:0] {
    GPX_S_IDLE = 5'h01,
    GPX_S_ADDR = 5'h02,
    GPX_S_CMD = 5'h04,
    GPX_S_WR = 5'h08,
    GPX_S_RD = 5'h10
  } gpx_fsm_t;
endpackage

// ==== design/gpx_link_if.sv ====
// Carries the received shift register from the serial clock domain.
// Assumes the word is read only while the serial clock is stable high.
interface gpx_link_if;
  logic [7:0] rx_byte;
  modport link (output rx_byte);
  modport core (input rx_byte);
endinterface

// ==== design/gpx_sync.sv ====
// Two-flop synchroniser for a group of unrelated level inputs.
// Assumes the bits are independent; no word coherence is promised.
module gpx_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } gpx_sync_st_t;
  gpx_sync_st_t st_r;
  gpx_sync_st_t st_nxt;

  always_comb
  begin
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;
endmodule

// ==== design/gpx_link_rx.sv ====
// Serial data shifter clocked by the bus clock itself.
// Assumes data is stable around each rising serial clock edge.
module gpx_link_rx (
  input wire logic scl_clk,
  input wire logic reset_n,
  input wire logic sda_i,
  gpx_link_if.link lk
);
  typedef struct packed {
    logic [7:0] shreg;
  } gpx_link_st_t;
  gpx_link_st_t st_r;
  gpx_link_st_t st_nxt;

  // Framing lives in the core domain; this side only shifts
  always_comb
  begin
    st_nxt.shreg = {st_r.shreg[6:0], sda_i};
  end

  always_ff @(posedge scl_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign lk.rx_byte = st_r.shreg;
endmodule

// ==== design/gpx_top.sv ====
// Serial-bus 16-bit GPIO expander core with register file and pins.
// Assumes a 250 MHz core clock well above the serial clock rate;
// the data and GPIO pins are split into input, output and output enable.
////////////////////////////////////////////////////////////////////////
// Functional notes
// [RULE1] Interrupt while input differs from stored value
// [RULE2] All pin interrupts masked after power-up
// [RULE3] Reset loads defaults and idles state machine
// [RULE4] Power-up: all inputs, pull-ups enabled
// [RULE5] Address from three select pins
// [RULE6] Interrupt is open-drain, active low
// [RULE7] Two 8-bit ports with four registers
// [RULE8] Per-port push-pull or open-drain outputs
// [RULE9] Read-only status shows interrupt source pins
// [RULE10] Two-bit drive strength per pin
// [RULE11] Latched input change held until read
// [RULE12] Per-pin pull resistor enable
// [RULE13] Per-pin pull-up or pull-down select
// [RULE14] Masked pins raise no interrupt
// [RULE15] Command byte stored as register pointer
// [RULE16] Address bit zero selects read or write
// [RULE17] Bit 6 selects extended registers
// [RULE18] Polarity bit inverts reported input
// [RULE19] Reading input port clears its interrupt
module gpx_top
  import gpx_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic scl_clk,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic slave_addr_sel_0,
  input wire logic slave_addr_sel_1,
  input wire logic slave_addr_sel_2,
  input wire logic [gpx_pkg::GPX_PIN_W-1:0] gpio_i,
  output logic [gpx_pkg::GPX_PIN_W-1:0] gpio_o,
  output logic [gpx_pkg::GPX_PIN_W-1:0] gpio_oe,
  output logic [2*gpx_pkg::GPX_PIN_W-1:0] drive_str,
  output logic [gpx_pkg::GPX_PIN_W-1:0] pull_en,
  output logic [gpx_pkg::GPX_PIN_W-1:0] pull_up_sel,
  output logic int_o,
  output logic int_oe
);
  import gpx_pkg::*;

  typedef struct packed {
    gpx_fsm_t fsm;
    logic scl_d;
    logic sda_d;
    logic clr;
    logic [3:0] bits;
    logic ack;
    logic mack;
    logic txen;
    logic [7:0] tx;
    logic [7:0] ptr;
    logic [15:0] outp;
    logic [15:0] pol;
    logic [15:0] cfg;
    logic [31:0] drv;
    logic [15:0] lat;
    logic [15:0] pen;
    logic [15:0] psel;
    logic [15:0] msk;
    logic [1:0] ocfg;
    logic [15:0] snap;
    logic [15:0] pend;
    logic [15:0] latv;
    logic [15:0] istat;
    logic [15:0] gpio_o;
    logic [15:0] gpio_oe;
    logic sda_oe;
    logic int_oe;
  } gpx_st_t;

  gpx_st_t st_r;
  gpx_st_t st_nxt;
  logic [20:0] sync_q;
  logic scl_s;
  logic sda_s;
  logic [2:0] asel_s;
  logic [15:0] pin_s;
  logic [15:0] pin_eff;
  logic [15:0] in_val;
  logic [15:0] chg_set;
  logic [15:0] rd_clr;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic byte_evt;
  logic addr_hit;
  logic rd_load;
  logic [7:0] rx;

  gpx_link_if lk ();

  ////////////////////////////////////////////////////////////////////////
  // Crossings and the serial-clock shifter

  gpx_sync #(.W(21)) u_sync (
    .clk (clk),
    .reset_n (reset_n),
    .d ({scl_clk, sda_i, slave_addr_sel_2, slave_addr_sel_1,
      slave_addr_sel_0, gpio_i}),
    .q (sync_q)
  );

  gpx_link_rx u_link (
    .scl_clk (scl_clk),
    .reset_n (reset_n),
    .sda_i (sda_i),
    .lk (lk.link)
  );

  assign scl_s = sync_q[20];
  assign sda_s = sync_q[19];
  assign asel_s = sync_q[18:16];
  assign pin_s = sync_q[15:0];
  // Word is sampled only just after a synced rise, long before it moves
  assign rx = lk.rx_byte;

  ////////////////////////////////////////////////////////////////////////
  // Register read view

  function automatic logic [7:0] rd_mux(input gpx_st_t s,
    input logic [15:0] iv);
    logic [7:0] v;
    v = 8'h00;
    case (s.ptr) // RULE17
      GPX_IN0: v = iv[7:0];
      GPX_IN1: v = iv[15:8];
      GPX_OUT0: v = s.outp[7:0];
      GPX_OUT1: v = s.outp[15:8];
      GPX_POL0: v = s.pol[7:0];
      GPX_POL1: v = s.pol[15:8];
      GPX_CFG0: v = s.cfg[7:0];
      GPX_CFG1: v = s.cfg[15:8];
      GPX_DRV0A: v = s.drv[7:0];
      GPX_DRV0B: v = s.drv[15:8];
      GPX_DRV1A: v = s.drv[23:16];
      GPX_DRV1B: v = s.drv[31:24];
      GPX_LAT0: v = s.lat[7:0];
      GPX_LAT1: v = s.lat[15:8];
      GPX_PEN0: v = s.pen[7:0];
      GPX_PEN1: v = s.pen[15:8];
      GPX_PSEL0: v = s.psel[7:0];
      GPX_PSEL1: v = s.psel[15:8];
      GPX_MSK0: v = s.msk[7:0];
      GPX_MSK1: v = s.msk[15:8];
      GPX_IST0: v = s.istat[7:0]; // RULE9
      GPX_IST1: v = s.istat[15:8]; // RULE9
      GPX_OCFG: v = {6'h00, s.ocfg};
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.scl_d = scl_s;
    st_nxt.sda_d = sda_s;
    scl_rise = scl_s && !st_r.scl_d;
    scl_fall = !scl_s && st_r.scl_d;
    start_c = scl_s && st_r.scl_d && st_r.sda_d && !sda_s;
    stop_c = scl_s && st_r.scl_d && !st_r.sda_d && sda_s;
    byte_evt = scl_rise && !st_r.clr && st_r.bits == GPX_LAST_DATA;
    addr_hit = rx[7:1] == {GPX_ADDR_BASE, asel_s}; // RULE5
    rd_load = scl_fall && !st_r.clr && st_r.bits == GPX_ACK_SLOT
      && st_r.fsm == GPX_S_RD && st_r.mack;
    pin_eff = pin_s ^ st_r.pol; // RULE18
    in_val = (st_r.pend & st_r.latv) | (~st_r.pend & pin_eff); // RULE11
    rd_clr = 16'h0000;
    if (rd_load && st_r.ptr == GPX_IN0)
    begin
      rd_clr[7:0] = 8'hFF;
    end
    if (rd_load && st_r.ptr == GPX_IN1)
    begin
      rd_clr[15:8] = 8'hFF;
    end
    // Reading the port refreshes the stored value and drops its latch
    st_nxt.snap = (st_r.snap & ~rd_clr) | (in_val & rd_clr); // RULE19
    st_nxt.pend = st_r.pend & ~rd_clr; // RULE11
    // Latch the first change only; later changes wait for the read
    for (int i = 0; i < GPX_PIN_W; i++)
    begin
      if (st_r.lat[i] && !st_r.pend[i] && !rd_clr[i]
        && pin_eff[i] != st_r.snap[i])
      begin
        st_nxt.pend[i] = 1'b1; // RULE11
        st_nxt.latv[i] = pin_eff[i];
      end
    end
    // Compare with the value just stored, so a read clears what it reported
    chg_set = ((pin_eff ^ st_nxt.snap) | st_nxt.pend)
      & ~st_r.msk; // RULE1 RULE14
    // A pin that moves after the read sets its status bit again
    st_nxt.istat = (st_r.istat & ~rd_clr) | chg_set; // RULE19
    st_nxt.int_oe = |st_r.istat; // RULE1 RULE6

    // Bit slot counter on serial clock falls
    if (scl_fall)
    begin
      if (st_r.clr)
      begin
        st_nxt.clr = 1'b0;
      end
      else if (st_r.bits == GPX_ACK_SLOT)
      begin
        st_nxt.bits = 4'h0;
        st_nxt.ack = 1'b0;
        st_nxt.txen = 1'b0;
        if (st_r.fsm == GPX_S_RD)
        begin
          if (st_r.mack)
          begin
            st_nxt.tx = rd_mux(st_r, in_val);
            st_nxt.txen = 1'b1;
            st_nxt.ptr = {st_r.ptr[7:1], ~st_r.ptr[0]};
          end
          else
          begin
            st_nxt.fsm = GPX_S_IDLE;
          end
        end
      end
      else
      begin
        st_nxt.bits = st_r.bits + 4'h1;
        if (st_r.txen)
        begin
          st_nxt.tx = {st_r.tx[6:0], 1'b0};
        end
      end
    end

    // Controller acknowledge of a byte we sent
    if (scl_rise && !st_r.clr && st_r.bits == GPX_ACK_SLOT
      && st_r.fsm == GPX_S_RD && st_r.txen)
    begin
      st_nxt.mack = !sda_s;
    end

    if (byte_evt)
    begin
      case (st_r.fsm)
        GPX_S_ADDR:
        begin
          st_nxt.ack = addr_hit;
          st_nxt.mack = 1'b1;
          if (!addr_hit)
          begin
            st_nxt.fsm = GPX_S_IDLE;
          end
          else if (rx[0]) // RULE16
          begin
            st_nxt.fsm = GPX_S_RD;
          end
          else
          begin
            st_nxt.fsm = GPX_S_CMD;
          end
        end
        GPX_S_CMD:
        begin
          st_nxt.ptr = rx; // RULE15
          st_nxt.ack = 1'b1;
          st_nxt.fsm = GPX_S_WR;
        end
        GPX_S_WR:
        begin
          st_nxt.ack = 1'b1;
          st_nxt.ptr = {st_r.ptr[7:1], ~st_r.ptr[0]};
          case (st_r.ptr) // RULE7 RULE17
            GPX_OUT0: st_nxt.outp[7:0] = rx;
            GPX_OUT1: st_nxt.outp[15:8] = rx;
            GPX_POL0: st_nxt.pol[7:0] = rx;
            GPX_POL1: st_nxt.pol[15:8] = rx;
            GPX_CFG0: st_nxt.cfg[7:0] = rx;
            GPX_CFG1: st_nxt.cfg[15:8] = rx;
            GPX_DRV0A: st_nxt.drv[7:0] = rx; // RULE10
            GPX_DRV0B: st_nxt.drv[15:8] = rx; // RULE10
            GPX_DRV1A: st_nxt.drv[23:16] = rx; // RULE10
            GPX_DRV1B: st_nxt.drv[31:24] = rx; // RULE10
            GPX_LAT0: st_nxt.lat[7:0] = rx;
            GPX_LAT1: st_nxt.lat[15:8] = rx;
            GPX_PEN0: st_nxt.pen[7:0] = rx; // RULE12
            GPX_PEN1: st_nxt.pen[15:8] = rx; // RULE12
            GPX_PSEL0: st_nxt.psel[7:0] = rx; // RULE13
            GPX_PSEL1: st_nxt.psel[15:8] = rx; // RULE13
            GPX_MSK0: st_nxt.msk[7:0] = rx; // RULE14
            GPX_MSK1: st_nxt.msk[15:8] = rx; // RULE14
            GPX_OCFG: st_nxt.ocfg = rx[1:0]; // RULE8
            default: st_nxt.ack = 1'b1;
          endcase
        end
        default: st_nxt.ack = 1'b0;
      endcase
    end

    // Start and stop override everything else on the bus side
    if (start_c)
    begin
      st_nxt.fsm = GPX_S_ADDR;
      st_nxt.clr = 1'b1;
      st_nxt.bits = 4'h0;
      st_nxt.ack = 1'b0;
      st_nxt.txen = 1'b0;
    end
    else if (stop_c)
    begin
      st_nxt.fsm = GPX_S_IDLE;
      st_nxt.clr = 1'b1;
      st_nxt.ack = 1'b0;
      st_nxt.txen = 1'b0;
    end

    // Data line: pull low for acknowledge or a zero data bit
    if (st_r.bits == GPX_ACK_SLOT && !st_r.clr)
    begin
      st_nxt.sda_oe = st_r.ack;
    end
    else
    begin
      st_nxt.sda_oe = st_r.txen && !st_r.clr && !st_r.tx[7];
    end

    // Open-drain ports only pull low; push-pull drives both levels
    st_nxt.gpio_o = st_r.outp;
    for (int p = 0; p < 2; p++)
    begin
      for (int b = 0; b < GPX_PORT_W; b++)
      begin
        st_nxt.gpio_oe[p*GPX_PORT_W+b] = !st_r.cfg[p*GPX_PORT_W+b]
          && !(st_r.ocfg[p] && st_r.outp[p*GPX_PORT_W+b]); // RULE8
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_r <= '0; // RULE3
      st_r.fsm <= GPX_S_IDLE; // RULE3
      st_r.clr <= 1'b1;
      // Match the synchroniser's reset; the idle-high serial clock still gives one rise, ignored while clr is set
      st_r.scl_d <= 1'b0;
      st_r.sda_d <= 1'b0;
      st_r.outp <= GPX_RST_OUT;
      st_r.pol <= GPX_RST_POL;
      st_r.cfg <= GPX_RST_CFG; // RULE4
      st_r.drv <= GPX_RST_DRV;
      st_r.lat <= GPX_RST_LAT;
      st_r.pen <= GPX_RST_PEN; // RULE4
      st_r.psel <= GPX_RST_PSEL; // RULE4
      st_r.msk <= GPX_RST_MSK; // RULE2
      st_r.ocfg <= GPX_RST_OCFG;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign sda_o = 1'b0;
  assign int_o = 1'b0;
  assign sda_oe = st_r.sda_oe;
  assign int_oe = st_r.int_oe;
  assign gpio_o = st_r.gpio_o;
  assign gpio_oe = st_r.gpio_oe;
  assign drive_str = st_r.drv;
  assign pull_en = st_r.pen;
  assign pull_up_sel = st_r.psel;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_addr_read;
    byte_evt && st_r.fsm == GPX_S_ADDR && addr_hit && rx[0];
  endsequence

  sequence s_cmd_byte;
    byte_evt && st_r.fsm == GPX_S_CMD && !start_c && !stop_c;
  endsequence

  property p_int_follows;
    @(posedge clk) disable iff (!reset_n)
    (st_r.istat != 16'h0000) |=> int_oe;
  endproperty
  a_int_follows: assert property (p_int_follows) // RULE1
    else $error("interrupt not driven while status pending");

  property p_int_quiet;
    @(posedge clk) disable iff (!reset_n)
    (st_r.istat == 16'h0000) |=> !int_oe;
  endproperty
  a_int_quiet: assert property (p_int_quiet) // RULE6
    else $error("interrupt driven with no status pending");

  property p_mask_blocks;
    @(posedge clk) disable iff (!reset_n)
    ((st_r.istat & st_r.msk) == 16'h0000)
      |=> ((st_r.istat & $past(st_r.msk)) == 16'h0000);
  endproperty
  a_mask_blocks: assert property (p_mask_blocks) // RULE14
    else $error("masked pin raised status");

  property p_out_only_cfg;
    @(posedge clk) disable iff (!reset_n)
    ##1 ((gpio_oe & $past(st_r.cfg)) == 16'h0000);
  endproperty
  a_out_only_cfg: assert property (p_out_only_cfg) // RULE4
    else $error("pin driven while configured as input");

  property p_open_drain;
    @(posedge clk) disable iff (!reset_n)
    ##1 ((gpio_oe & $past(st_r.outp)
      & {{8{$past(st_r.ocfg[1])}}, {8{$past(st_r.ocfg[0])}}}) == 16'h0000);
  endproperty
  a_open_drain: assert property (p_open_drain) // RULE8
    else $error("open-drain pin driven high");

  property p_read_dir;
    @(posedge clk) disable iff (!reset_n)
    s_addr_read ##1 !start_c && !stop_c |-> st_r.fsm == GPX_S_RD
      && st_r.ack;
  endproperty
  a_read_dir: assert property (p_read_dir) // RULE16
    else $error("read address did not enter read phase");

  property p_cmd_ptr;
    @(posedge clk) disable iff (!reset_n)
    s_cmd_byte |=> st_r.ptr == $past(rx) && st_r.fsm == GPX_S_WR;
  endproperty
  a_cmd_ptr: assert property (p_cmd_ptr) // RULE15
    else $error("command byte not stored as pointer");

  property p_read_clears;
    @(posedge clk) disable iff (!reset_n)
    (rd_load && st_r.ptr == GPX_IN0)
      |=> ((st_r.istat[7:0] & ~$past(chg_set[7:0])) == 8'h00);
  endproperty
  a_read_clears: assert property (p_read_clears) // RULE19
    else $error("input read left status set");

  property p_latch_holds;
    @(posedge clk) disable iff (!reset_n)
    (rd_clr == 16'h0000) |=> ((st_r.pend & $past(st_r.pend))
      == $past(st_r.pend)) && ((st_r.latv & $past(st_r.pend))
      == ($past(st_r.latv) & $past(st_r.pend)));
  endproperty
  a_latch_holds: assert property (p_latch_holds) // RULE11
    else $error("latched input lost before read");

  property p_mask_write;
    @(posedge clk) disable iff (!reset_n)
    (byte_evt && st_r.fsm == GPX_S_WR && st_r.ptr == GPX_MSK1
      && !start_c && !stop_c) |=> st_r.msk[15:8] == $past(rx);
  endproperty
  a_mask_write: assert property (p_mask_write) // RULE17
    else $error("extended mask register not written");
endmodule

// ==== verification/gpx_master.sv ====
// Behavioural two-wire bus controller facing the expander's serial pins.
// Assumes the bench resolves the data line with a pull-up.
module gpx_master (
  output logic scl,
  output logic sda_low,
  input wire logic sda_line
);
  timeunit 1ns;
  timeprecision 100ps;
  ////////////////////////////////////////////////////////////////////////
  // Clock stands high and data is released between frames
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // Start or repeated start; data is released while clock is low, then pulled low while clock is high
  task automatic start();
    sda_low = 1'b0;
    #40;
    scl = 1'b1;
    #40;
    sda_low = 1'b1;
    #40;
    scl = 1'b0;
    #40;
  endtask
  // One bit of a 160 ns clock period; line sampled mid high phase
  task automatic bit_x(input logic b, output logic r);
    sda_low = !b;
    #40;
    scl = 1'b1;
    #40;
    r = sda_line;
    #40;
    scl = 1'b0;
    #40;
  endtask
  // Byte MSB first plus the acknowledge slot; ack_in low drives ACK
  task automatic xfer(input logic [7:0] d, input logic ack_in,
                      output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_x(d[i], r);
      q[i] = r;
    end
    bit_x(ack_in, r);
    ack = !r;
  endtask
  task automatic stop();
    sda_low = 1'b1;
    #40;
    scl = 1'b1;
    #40;
    sda_low = 1'b0;
    #80;
  endtask
endmodule

// ==== verification/gpx_top_bench.sv ====
// Self-checking bench for the serial GPIO expander top.
// Assumes the controller model drives the serial pins; pins resolved here.
module gpx_top_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import gpx_pkg::*;
  logic clk;
  logic reset_n;
  logic scl;
  logic sda_low;
  logic sda_line;
  logic sda_o;
  logic sda_oe;
  logic [2:0] sel;
  logic [15:0] ext;
  logic [15:0] gpio_i;
  logic [15:0] gpio_o;
  logic [15:0] gpio_oe;
  logic [31:0] drive_str;
  logic [15:0] pull_en;
  logic [15:0] pull_up_sel;
  logic int_o;
  logic int_oe;
  logic int_n;
  logic [31:0] seed = 32'h0000_43b8;
  int bad_count = 0;
  int n_compared = 0;
  // Open-drain lines with pull-ups; driven pins win over outside level
  assign sda_line = !(sda_low || (sda_oe && !sda_o));
  assign int_n = !(int_oe && !int_o);
  assign gpio_i = (gpio_oe & gpio_o) | (~gpio_oe & ext);
  gpx_master m (.scl(scl), .sda_low(sda_low), .sda_line(sda_line));
  gpx_top dut (.clk(clk), .reset_n(reset_n), .scl_clk(scl),
    .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
    .slave_addr_sel_0(sel[0]), .slave_addr_sel_1(sel[1]),
    .slave_addr_sel_2(sel[2]), .gpio_i(gpio_i), .gpio_o(gpio_o),
    .gpio_oe(gpio_oe), .drive_str(drive_str), .pull_en(pull_en),
    .pull_up_sel(pull_up_sel), .int_o(int_o), .int_oe(int_oe));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] rnd16();
    logic [31:0] r;
    r = rnd();
    return r[15:0];
  endfunction
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: flag %b want %b", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Writes a register pair, low port first
  task automatic reg_wr(input logic [7:0] cmd, input logic [15:0] v);
    logic [7:0] q;
    logic [3:0] acks;
    m.start();
    m.xfer({GPX_ADDR_BASE, sel, 1'b0}, 1'b1, q, acks[0]);
    m.xfer(cmd, 1'b1, q, acks[1]);
    m.xfer(v[7:0], 1'b1, q, acks[2]);
    m.xfer(v[15:8], 1'b1, q, acks[3]);
    m.stop();
    chk_bit(&acks, 1'b1);
    repeat (12) @(posedge clk);
  endtask
  // Without a command byte the stored pointer is used
  task automatic reg_rd(input logic [7:0] cmd, input logic cmd_en,
                        output logic [15:0] v);
    logic [7:0] q;
    logic a;
    m.start();
    if (cmd_en)
    begin
      m.xfer({GPX_ADDR_BASE, sel, 1'b0}, 1'b1, q, a);
      m.xfer(cmd, 1'b1, q, a);
      m.start();
    end
    m.xfer({GPX_ADDR_BASE, sel, 1'b1}, 1'b1, q, a);
    chk_bit(a, 1'b1);
    m.xfer(8'hff, 1'b0, v[7:0], a);
    m.xfer(8'hff, 1'b1, v[15:8], a);
    m.stop();
  endtask
  task automatic rd_chk(input logic [7:0] cmd, input logic [15:0] exp);
    logic [15:0] v;
    reg_rd(cmd, 1'b1, v);
    chk_val(v, exp);
  endtask
  // Pins move just after a core edge, then the synchronisers fill
  task automatic set_pins(input logic [15:0] v);
    @(posedge clk);
    #1;
    ext = v;
    repeat (20) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Generous bound: the full sequence needs well under this
  initial
  begin
    #350000;
    bad_count++;
    tally_and_finish();
  end
  initial
  begin
    logic [7:0] q;
    logic a;
    logic [15:0] v;
    logic [15:0] c;
    logic [15:0] p;
    logic [15:0] b;
    logic [31:0] d;
    reset_n = 1'b0;
    d = rnd();
    sel = d[2:0];
    ext = rnd16();
    repeat (4) @(posedge clk);
    #1;
    reset_n = 1'b1;
    repeat (8) @(posedge clk);
    chk_val(gpio_oe, 16'h0000);
    chk_val(pull_en & pull_up_sel, 16'hffff);
    chk_val(drive_str[15:0], GPX_RST_DRV[15:0]);
    chk_bit(int_n, 1'b1);
    rd_chk(GPX_MSK0, GPX_RST_MSK);
    rd_chk(GPX_CFG0, GPX_RST_CFG);
    rd_chk(GPX_OUT0, GPX_RST_OUT);
    for (int i = 1; i < 8; i++)
    begin
      m.start();
      m.xfer({GPX_ADDR_BASE, sel ^ i[2:0], 1'b0}, 1'b1, q, a);
      m.stop();
      chk_bit(a, 1'b0);
    end
    v = rnd16();
    c = rnd16();
    reg_wr(GPX_OUT0, v);
    reg_wr(GPX_CFG0, c);
    chk_val(gpio_o, v);
    chk_val(gpio_oe, ~c);
    rd_chk(GPX_OUT0, v);
    reg_wr(GPX_OCFG, 16'h0001);
    chk_val(gpio_oe, ~c & {8'hff, ~v[7:0]});
    reg_wr(GPX_OCFG, 16'h0002);
    chk_val(gpio_oe, ~c & {~v[15:8], 8'hff});
    d = rnd();
    reg_wr(GPX_DRV0A, d[15:0]);
    reg_wr(GPX_DRV1A, d[31:16]);
    chk_val(drive_str[15:0], d[15:0]);
    chk_val(drive_str[31:16], d[31:16]);
    reg_wr(GPX_PEN0, d[15:0]);
    reg_wr(GPX_PSEL0, d[31:16]);
    chk_val(pull_en, d[15:0]);
    chk_val(pull_up_sel, d[31:16]);
    reg_wr(GPX_CFG0, 16'hffff);
    p = rnd16();
    reg_wr(GPX_POL0, p);
    set_pins(rnd16());
    rd_chk(GPX_IN0, ext ^ p);
    set_pins(~ext);
    chk_bit(int_n, 1'b1);
    rd_chk(GPX_IN0, ext ^ p);
    reg_wr(GPX_MSK0, 16'hff00);
    set_pins(ext ^ 16'h0101);
    chk_bit(int_n, 1'b0);
    rd_chk(GPX_IST0, 16'h0001);
    rd_chk(GPX_IN0, ext ^ p);
    repeat (12) @(posedge clk);
    chk_bit(int_n, 1'b1);
    reg_wr(GPX_LAT0, 16'h00ff);
    b = ext;
    set_pins(b ^ 16'h00f0);
    set_pins(b);
    rd_chk(GPX_IN0, b ^ p ^ 16'h00f0);
    rd_chk(GPX_IN0, b ^ p);
    reg_wr(GPX_IST0, 16'hffff);
    rd_chk(GPX_IST0, 16'h0000);
    reg_wr(GPX_POL0, p);
    reg_rd(8'h00, 1'b0, v);
    chk_val(v, p);
    rd_chk(8'h4e, 16'h0200);
    @(posedge clk);
    #1;
    reset_n = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    reset_n = 1'b1;
    repeat (8) @(posedge clk);
    chk_val(gpio_oe, 16'h0000);
    rd_chk(GPX_MSK0, GPX_RST_MSK);
    rd_chk(GPX_POL0, GPX_RST_POL);
    tally_and_finish();
  end
endmodule
